// >>> core/twl_map.vh
// Purpose: Constants for the three-wire register load port.
// Assumes: Included by twl_load_port.v and twl_reg_mem.v.
// Notes: Field positions of the decoded control bits are local choices.
`ifndef TWL_MAP_VH
`define TWL_MAP_VH

// Serial word layout
`define TWL_WORD_BITS 32
`define TWL_ADDR_BITS 4
`define TWL_ADDR_LSB 0
`define TWL_ADDR_MSB 3
`define TWL_REG_COUNT 16

// Power control register and its fields
`define TWL_PWR_REG_IDX 4'h4
`define TWL_PWR_DOWN_BIT 5
`define TWL_PUMP_TRI_BIT 4
`define TWL_MUX_SEL_LSB 27
`define TWL_MUX_SEL_MSB 29

// Output stage register and its field
`define TWL_OUT_REG_IDX 4'h6
`define TWL_OUT_A_EN_BIT 6

// Monitor multiplexer selections
`define TWL_MUX_LOW 3'h0
`define TWL_MUX_DIG_LOCK 3'h1
`define TWL_MUX_ANA_LOCK 3'h2
`define TWL_MUX_RF_DIV 3'h3
`define TWL_MUX_REF_DIV 3'h4

// Reset values
`define TWL_RST_PWR_DOWN 1'h0
`define TWL_RST_PUMP_TRI 1'h0
`define TWL_RST_OUT_A_EN 1'h1
`define TWL_RST_MUX_SEL 3'h0
`define TWL_RST_WORD 32'h00000000

`endif

// >>> core/twl_reg_mem.v
// Purpose: Bank of programmed registers, one write port, one read port.
// Assumes: Single clock; read data registered one cycle after the address.
// Notes: Contents are not cleared by reset, only the read register is.
`timescale 1ns/100ps
`include "twl_map.vh"

module twl_reg_mem #(
  parameter WIDTH = `TWL_WORD_BITS,
  parameter ABITS = `TWL_ADDR_BITS
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [ABITS-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire [ABITS-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_q
);

  reg [WIDTH-1:0] mem_q [0:(1<<ABITS)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= {WIDTH{1'b0}};
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule // twl_reg_mem

// >>> core/twl_load_port.v
// Purpose: Three-wire serial write port and pin-level power and monitor control.
// Assumes: Serial pins and control pins are asynchronous to clk and are
//   resynchronised; serial clock is far slower than clk.
// Notes: Operation is described in the comments beside each block.
`timescale 1ns/100ps
`include "twl_map.vh"

module twl_load_port #(
  parameter WORD_BITS = `TWL_WORD_BITS,
  parameter ADDR_BITS = `TWL_ADDR_BITS
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Serial write pins
  input wire ser_clk,
  input wire ser_data,
  input wire load_strobe,
  // Power control pins
  input wire chip_enable,
  input wire out_a_power_down_n,
  // Internal monitor sources, same clock domain
  input wire dig_lock,
  input wire ana_lock,
  input wire rf_div_scaled,
  input wire ref_div_scaled,
  // Register read-back
  input wire [ADDR_BITS-1:0] rd_addr,
  output wire [WORD_BITS-1:0] rd_data_q,
  // Section enables
  output reg core_power_on_q,
  output reg pump_output_oe_q,
  output reg main_rf_output_en_q,
  // Monitor output and load event
  output reg monitor_mux_output_q,
  output reg word_loaded_q,
  output reg [ADDR_BITS-1:0] loaded_addr_q
);

  // Pin order inside the synchroniser vectors
  localparam PIN_SCLK = 0;
  localparam PIN_SDATA = 1;
  localparam PIN_LOAD = 2;
  localparam PIN_CE = 3;
  localparam PIN_PDN = 4;
  localparam PIN_COUNT = 5;

  // Two-stage synchronisers; the first stage feeds only the second
  reg [PIN_COUNT-1:0] pin_meta_q;
  reg [PIN_COUNT-1:0] pin_sync_q;
  // Delayed copies for edge detection
  reg sclk_prev_q;
  reg load_prev_q;

  wire [PIN_COUNT-1:0] pin_raw;
  wire sclk_rise;
  wire load_rise;

  assign pin_raw = {out_a_power_down_n, chip_enable, load_strobe, ser_data, ser_clk};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= {PIN_COUNT{1'b0}};
      pin_sync_q <= {PIN_COUNT{1'b0}};
      sclk_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= pin_sync_q[PIN_SCLK];
      load_prev_q <= pin_sync_q[PIN_LOAD];
    end
  end

  // Data travels through the same two stages as the serial clock, so the bit
  // seen at the detected edge is the one present at the pin edge.
  assign sclk_rise = pin_sync_q[PIN_SCLK] & ~sclk_prev_q;
  assign load_rise = pin_sync_q[PIN_LOAD] & ~load_prev_q;

  // Serial shift register
  reg [WORD_BITS-1:0] shift_q;
  reg [WORD_BITS-1:0] shift_d;

  always @* begin
    shift_d = shift_q;
    if (sclk_rise) begin
      shift_d = {shift_q[WORD_BITS-2:0], pin_sync_q[PIN_SDATA]};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= `TWL_RST_WORD;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Destination select is the last bits shifted in
  wire [ADDR_BITS-1:0] word_addr;
  assign word_addr = shift_q[`TWL_ADDR_MSB:`TWL_ADDR_LSB];

  // Register bank; written only on a load strobe rise
  twl_reg_mem #(
    .WIDTH(WORD_BITS),
    .ABITS(ADDR_BITS)
  ) u_reg_mem (
    .clk(clk),
    .rst(rst),
    .wr_en(load_rise),
    .wr_addr(word_addr),
    .wr_data(shift_q),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data_q)
  );

  // Shadow copies of the control fields that steer logic here. Keeping them
  // in flops avoids a read port on the bank for every field.
  reg sw_power_down_q;
  reg sw_power_down_d;
  reg pump_tristate_q;
  reg pump_tristate_d;
  reg out_a_enable_q;
  reg out_a_enable_d;
  reg [2:0] mux_sel_q;
  reg [2:0] mux_sel_d;

  always @* begin
    sw_power_down_d = sw_power_down_q;
    pump_tristate_d = pump_tristate_q;
    out_a_enable_d = out_a_enable_q;
    mux_sel_d = mux_sel_q;
    if (load_rise) begin
      if (word_addr == `TWL_PWR_REG_IDX) begin
        sw_power_down_d = shift_q[`TWL_PWR_DOWN_BIT];
        pump_tristate_d = shift_q[`TWL_PUMP_TRI_BIT];
        mux_sel_d = shift_q[`TWL_MUX_SEL_MSB:`TWL_MUX_SEL_LSB];
      end
      if (word_addr == `TWL_OUT_REG_IDX) begin
        out_a_enable_d = shift_q[`TWL_OUT_A_EN_BIT];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_power_down_q <= `TWL_RST_PWR_DOWN;
      pump_tristate_q <= `TWL_RST_PUMP_TRI;
      out_a_enable_q <= `TWL_RST_OUT_A_EN;
      mux_sel_q <= `TWL_RST_MUX_SEL;
    end else begin
      sw_power_down_q <= sw_power_down_d;
      pump_tristate_q <= pump_tristate_d;
      out_a_enable_q <= out_a_enable_d;
      mux_sel_q <= mux_sel_d;
    end
  end

  // Section enables
  wire ce_sync;
  wire pdn_sync;
  wire core_on;
  assign ce_sync = pin_sync_q[PIN_CE];
  assign pdn_sync = pin_sync_q[PIN_PDN];
  assign core_on = ce_sync & ~sw_power_down_q;

  reg monitor_d;

  always @* begin
    case (mux_sel_q)
      `TWL_MUX_DIG_LOCK: begin
        monitor_d = dig_lock;
      end
      `TWL_MUX_ANA_LOCK: begin
        monitor_d = ana_lock;
      end
      `TWL_MUX_RF_DIV: begin
        monitor_d = rf_div_scaled;
      end
      `TWL_MUX_REF_DIV: begin
        monitor_d = ref_div_scaled;
      end
      default: begin
        monitor_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      core_power_on_q <= 1'b0;
      pump_output_oe_q <= 1'b0;
      main_rf_output_en_q <= 1'b0;
      monitor_mux_output_q <= 1'b0;
    end else begin
      core_power_on_q <= core_on;
      // Pump floats whenever the chip is off, whatever the tristate bit says
      pump_output_oe_q <= core_on & ~pump_tristate_q;
      // Pin and bit each disable the pair alone; nothing else depends on them
      main_rf_output_en_q <= core_on & pdn_sync & out_a_enable_q;
      // Monitor keeps running while powered down so lock can still be watched
      monitor_mux_output_q <= monitor_d;
    end
  end

  // Load event report
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      word_loaded_q <= 1'b0;
      loaded_addr_q <= {ADDR_BITS{1'b0}};
    end else begin
      word_loaded_q <= load_rise;
      if (load_rise) begin
        loaded_addr_q <= word_addr;
      end
    end
  end

endmodule // twl_load_port

// >>> verification/twl_host_model.sv
// Purpose: Host that shifts words into the three-wire write port.
// Assumes: Bit timing is paced by the system clock, 16 cycles a bit.
// Notes: Serial clock stands low between words.
`timescale 1ns/100ps
module twl_host_model (
  // Pacing clock
  input wire clk,
  // Serial write pins
  output reg ser_clk,
  output reg ser_data,
  output reg load_strobe
);
  integer i;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  task send(input [31:0] w, input ld);
    begin
      for (i = 31; i >= 0; i = i - 1) begin
        ser_data = w[i];
        repeat (8) @(posedge clk);
        #1 ser_clk = 1'b1;
        repeat (8) @(posedge clk);
        #1 ser_clk = 1'b0;
      end
      // Released data line must not look like a valid bit
      ser_data = ~ser_data;
      repeat (4) @(posedge clk);
      #1 load_strobe = ld;
      repeat (8) @(posedge clk);
      #1 load_strobe = 1'b0;
      repeat (8) @(posedge clk);
      #1;
    end
  endtask
endmodule // twl_host_model

// >>> verification/twl_load_port_properties.sv
// Purpose: Timing relations at the ports of the load port.
// Assumes: Pins are held at least 3 cycles, as the host does.
// Notes: Latencies follow the synchroniser depth.
`timescale 1ns/100ps
module twl_load_port_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins
  input wire load_strobe,
  input wire chip_enable,
  input wire out_a_power_down_n,
  // Outputs
  input wire core_power_on_q,
  input wire pump_output_oe_q,
  input wire main_rf_output_en_q,
  input wire word_loaded_q,
  input wire [3:0] loaded_addr_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ce_low_off: assert property (!chip_enable [*3] |=> !core_power_on_q && !pump_output_oe_q)
    else $error("power on with enable low");
  a_pump_needs_core: assert property (pump_output_oe_q |-> core_power_on_q)
    else $error("pump driven while off");
  a_rf_needs_core: assert property (main_rf_output_en_q |-> core_power_on_q)
    else $error("rf on while off");
  a_pin_rf_off: assert property (!out_a_power_down_n [*3] |=> !main_rf_output_en_q)
    else $error("rf on with pin low");
  a_load_ack: assert property ($rose(load_strobe) |-> ##[3:4] word_loaded_q)
    else $error("load not seen");
  a_load_pulse: assert property (word_loaded_q |=> !word_loaded_q)
    else $error("load pulse too long");
  a_load_cause: assert property (word_loaded_q |-> $past(load_strobe, 3))
    else $error("load without strobe");
  a_addr_moves: assert property ($changed(loaded_addr_q) |-> word_loaded_q)
    else $error("address moved without load");
endmodule // twl_load_port_properties
bind twl_load_port twl_load_port_properties chk_u (
  .clk(clk),
  .rst(rst),
  .load_strobe(load_strobe),
  .chip_enable(chip_enable),
  .out_a_power_down_n(out_a_power_down_n),
  .core_power_on_q(core_power_on_q),
  .pump_output_oe_q(pump_output_oe_q),
  .main_rf_output_en_q(main_rf_output_en_q),
  .word_loaded_q(word_loaded_q),
  .loaded_addr_q(loaded_addr_q)
);

// >>> verification/three_wire_register_load_port_test.sv
// Purpose: Scenario bench for the three-wire load port.
// Assumes: Outputs settle within 5 cycles of a pin change.
// Notes: Bank is read back through rd_addr.
`timescale 1ns/100ps
module three_wire_register_load_port_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg chip_enable = 1'b1;
  reg out_a_power_down_n = 1'b1;
  reg dig_lock = 1'b0, ana_lock = 1'b0, rf_div_scaled = 1'b0, ref_div_scaled = 1'b0;
  reg [3:0] rd_addr = 4'h0;
  reg [3:0] src;
  wire ser_clk, ser_data, load_strobe, core_power_on_q, pump_output_oe_q;
  wire main_rf_output_en_q, monitor_mux_output_q, word_loaded_q;
  wire [31:0] rd_data_q;
  wire [3:0] loaded_addr_q;
  integer err_count = 0;
  integer checked = 0;
  integer s;
  always #5 clk = ~clk;
  twl_host_model host_u (
    .clk(clk),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .load_strobe(load_strobe)
  );
  twl_load_port dut_u (
    .clk(clk),
    .rst(rst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .load_strobe(load_strobe),
    .chip_enable(chip_enable),
    .out_a_power_down_n(out_a_power_down_n),
    .dig_lock(dig_lock),
    .ana_lock(ana_lock),
    .rf_div_scaled(rf_div_scaled),
    .ref_div_scaled(ref_div_scaled),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data_q),
    .core_power_on_q(core_power_on_q),
    .pump_output_oe_q(pump_output_oe_q),
    .main_rf_output_en_q(main_rf_output_en_q),
    .monitor_mux_output_q(monitor_mux_output_q),
    .word_loaded_q(word_loaded_q),
    .loaded_addr_q(loaded_addr_q)
  );
  task chk(input [79:0] name, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task outs(input [2:0] exp);
    begin
      step(5);
      chk("enables", {29'h0, exp}, {29'h0, core_power_on_q, pump_output_oe_q,
        main_rf_output_en_q});
    end
  endtask
  task t_power;
    begin
      outs(3'b111);
      host_u.send(32'h00000024, 1'b1);
      outs(3'b000);
      host_u.send(32'h00000014, 1'b1);
      outs(3'b101);
      host_u.send(32'h00000004, 1'b1);
      chip_enable = 1'b0;
      outs(3'b000);
      chip_enable = 1'b1;
      out_a_power_down_n = 1'b0;
      outs(3'b110);
      out_a_power_down_n = 1'b1;
      host_u.send(32'h00000006, 1'b1);
      outs(3'b110);
      host_u.send(32'h00000046, 1'b1);
      outs(3'b111);
    end
  endtask
  task t_load;
    begin
      host_u.send(32'h5a3c96e3, 1'b1);
      chk("addr", 32'h3, {28'h0, loaded_addr_q});
      rd_addr = 4'h3;
      step(2);
      chk("reg3", 32'h5a3c96e3, rd_data_q);
      host_u.send(32'h01234563, 1'b0);
      chk("reg3 kept", 32'h5a3c96e3, rd_data_q);
      host_u.send(32'hfedcba93, 1'b1);
      chk("reg3 new", 32'hfedcba93, rd_data_q);
      // A power-down word shifted without a strobe must not reach the shadow fields
      host_u.send(32'h00000024, 1'b0);
      outs(3'b111);
    end
  endtask
  task t_reset;
    begin
      host_u.send(32'h00000014, 1'b1);
      outs(3'b101);
      rst = 1'b1;
      step(2);
      chk("reset outs", 32'h0, {28'h0, word_loaded_q, core_power_on_q, pump_output_oe_q,
        main_rf_output_en_q});
      chk("reset addr", 32'h0, {28'h0, loaded_addr_q});
      rst = 1'b0;
      // Shadow fields return to their defaults, so every section comes back
      outs(3'b111);
    end
  endtask
  task t_mux;
    begin
      for (s = 0; s < 8; s = s + 1) begin
        host_u.send({2'h0, s[2:0], 23'h0, 4'h4}, 1'b1);
        src = (s >= 1 && s <= 4) ? 4'h1 << (s - 1) : 4'hf;
        {ref_div_scaled, rf_div_scaled, ana_lock, dig_lock} = src;
        step(3);
        chk("mux", {31'h0, s >= 1 && s <= 4}, {31'h0, monitor_mux_output_q});
        {ref_div_scaled, rf_div_scaled, ana_lock, dig_lock} = ~src;
        step(3);
        chk("mux inv", 32'h0, {31'h0, monitor_mux_output_q});
      end
    end
  endtask
  task conclude;
    begin
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    step(8);
    rst = 1'b0;
    step(2);
    t_power;
    t_load;
    t_mux;
    t_reset;
    conclude;
  end
  initial begin
    #300000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // three_wire_register_load_port_test
